// >>> pwm_pkg.sv
// Shared constants for the fixed-period pulse width modulator
`default_nettype none
package pwm_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int MV_W = 12;
   localparam int TIME_W = 16;
   localparam int TENTHS_W = 20;
   localparam int NUM_INST = 2;

   // Register word addresses, one block of four per instance
   localparam logic [7:0] OFS_MV = 8'h00;
   localparam logic [7:0] OFS_PERIOD = 8'h04;
   localparam logic [7:0] OFS_MIN = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0c;
   localparam logic [7:0] INST_STRIDE = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

   localparam int CTRL_EN_BIT = 0;
   localparam int STATUS_ERR_LSB = 0;
   localparam int STATUS_OUT_LSB = 2;
   localparam int STATUS_EN_LSB = 4;

   localparam logic [MV_W-1:0] MV_FULL = 12'hfff;
   localparam logic [MV_W-1:0] MV_RST = 12'h000;
   localparam logic [TIME_W-1:0] PERIOD_MIN_MS = 16'h0005;
   localparam logic [TIME_W-1:0] PERIOD_RST = 16'h0005;
   localparam logic [TIME_W-1:0] MIN_RST = 16'h0000;

   // Internal time unit is 0.1 ms
   localparam logic [TENTHS_W-1:0] TENTHS_PER_MS = 20'h0000a;
   localparam logic [TENTHS_W-1:0] MIN_FALLBACK_TENTHS = 20'h00001;
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_US = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
endpackage
`default_nettype wire

// >>> pwm_link_if.sv
// Settings and results passed between the register file and one modulator
`default_nettype none
interface pwm_link_if;
   logic ce;
   logic enable;
   logic [pwm_pkg::MV_W-1:0] mv;
   logic [pwm_pkg::TIME_W-1:0] period;
   logic [pwm_pkg::TIME_W-1:0] min_time;
   logic pwm;
   logic err;
   modport ctl (output ce, enable, mv, period, min_time, input pwm, err);
   modport gen (input ce, enable, mv, period, min_time, output pwm, err);
endinterface
`default_nettype wire

// >>> pwm_modulator.sv
// One fixed-period modulator with minimum on/off time check
`default_nettype none
module pwm_modulator #(
   parameter int TICK_CYCLES = pwm_pkg::TICK_CYCLES
) (
   input wire logic clk_i, // Core clock
   input wire logic reset_n_i, // Async reset, active low
   pwm_link_if.gen link // Settings in, waveform out
);
   localparam int PRESC_W = $clog2(TICK_CYCLES);
   localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);

   typedef enum {ST_IDLE, ST_RUN} mod_state_t;

   mod_state_t state;
   logic [PRESC_W-1:0] presc;
   logic [pwm_pkg::TENTHS_W-1:0] cnt;
   logic [pwm_pkg::MV_W-1:0] mv_lat;
   logic [pwm_pkg::TENTHS_W-1:0] per_t;
   logic [pwm_pkg::TENTHS_W-1:0] min_t;
   logic [31:0] hi_prod;
   logic [31:0] lo_prod;
   logic [31:0] min_prod;
   logic [31:0] pos_prod;
   logic too_short;
   logic too_long;
   logic next_pwm;

   function automatic logic [31:0] scale(input logic [pwm_pkg::TENTHS_W-1:0] a, input logic [pwm_pkg::MV_W-1:0] b);
      return 32'(a) * 32'(b);
   endfunction

   function automatic logic [pwm_pkg::TENTHS_W-1:0] tenths(input logic [pwm_pkg::TIME_W-1:0] ms);
      logic [pwm_pkg::TENTHS_W-1:0] t;
      t = 20'(20'(ms) * pwm_pkg::TENTHS_PER_MS);
      return (ms == '0) ? pwm_pkg::MIN_FALLBACK_TENTHS : t;
   endfunction

   // Settings are taken only at a period boundary so a period never stretches
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ST_IDLE;
         presc <= '0;
         cnt <= '0;
         mv_lat <= pwm_pkg::MV_RST;
         per_t <= '0;
         min_t <= '0;
      end else if (link.ce) begin
         case (state)
            ST_IDLE: begin
               if (link.enable) begin
                  state <= ST_RUN;
                  presc <= '0;
                  cnt <= '0;
                  mv_lat <= link.mv;
                  per_t <= tenths(link.period);
                  min_t <= tenths(link.min_time);
               end
            end
            ST_RUN: begin
               if (!link.enable) begin
                  state <= ST_IDLE;
               end else if (presc == PRESC_LAST) begin
                  presc <= '0;
                  if (cnt == per_t - 20'h00001) begin
                     cnt <= '0;
                     mv_lat <= link.mv;
                     per_t <= tenths(link.period);
                     min_t <= tenths(link.min_time);
                  end else begin
                     cnt <= cnt + 20'h00001;
                  end
               end else begin
                  presc <= presc + PRESC_W'(1);
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // High time = mv * period / 4095, compared without a divider
   always_comb begin
      hi_prod = scale(per_t, mv_lat);
      lo_prod = scale(per_t, pwm_pkg::MV_FULL - mv_lat);
      min_prod = scale(min_t, pwm_pkg::MV_FULL);
      pos_prod = scale(cnt, pwm_pkg::MV_FULL);
      too_short = hi_prod < min_prod;
      too_long = lo_prod < min_prod;
      if (too_short) begin
         next_pwm = 1'b0;
      end else if (too_long) begin
         next_pwm = 1'b1;
      end else begin
         next_pwm = pos_prod < hi_prod;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link.pwm <= 1'b0;
         link.err <= 1'b0;
      end else if (link.ce) begin
         if (state != ST_RUN || !link.enable) begin
            link.pwm <= 1'b0;
            link.err <= 1'b0;
         end else begin
            link.pwm <= next_pwm;
            link.err <= too_short | too_long;
         end
      end
   end
endmodule // pwm_modulator
`default_nettype wire

// >>> pwm_output_block.sv
// Register file, two modulators and output drive for the PWM outputs
`default_nettype none
module pwm_output_block #(
   parameter int TICK_CYCLES = pwm_pkg::TICK_CYCLES
) (
   input wire logic CORE_CLK_I, // Core clock, 40 MHz
   input wire logic RESET_N_I, // Async reset, active low
   input wire logic CE_I, // Clock enable, freezes all state when low
   input wire logic [pwm_pkg::ADDR_W-1:0] ADDR_I, // Register address
   input wire logic [pwm_pkg::DATA_W-1:0] WDATA_I, // Write data
   input wire logic WRITE_I, // Write strobe
   input wire logic READ_I, // Read strobe
   input wire logic [pwm_pkg::NUM_INST-1:0] OTHER_DRIVE_I, // Other sources of each output
   output logic [pwm_pkg::DATA_W-1:0] RDATA_O, // Read data, cycle after read strobe
   output logic [pwm_pkg::NUM_INST-1:0] DIGITAL_OUTPUT_O, // Bit 0 output one, bit 1 output two
   output logic [pwm_pkg::NUM_INST-1:0] TIMING_ERROR_FLAG_O, // Live minimum-time error per instance
   output logic IRQ_O // Level interrupt
);
   localparam int N = pwm_pkg::NUM_INST;

   logic [pwm_pkg::MV_W-1:0] mv_reg [N];
   logic [pwm_pkg::TIME_W-1:0] period_reg [N];
   logic [pwm_pkg::TIME_W-1:0] min_reg [N];
   logic [N-1:0] modulator_enable_coil;
   logic [N-1:0] err_prev;
   logic [N-1:0] irq_status;
   logic [N-1:0] irq_mask;
   logic [N-1:0] gen_pwm;
   logic [N-1:0] gen_err;
   logic [N-1:0] err_event;
   logic [N-1:0] status_clear;
   logic [pwm_pkg::DATA_W-1:0] next_rdata;

   function automatic logic [pwm_pkg::ADDR_W-1:0] reg_addr(input int inst, input logic [7:0] ofs);
      return 8'(ofs + pwm_pkg::INST_STRIDE * 8'(inst));
   endfunction

   function automatic logic hit_write(input logic [pwm_pkg::ADDR_W-1:0] a);
      return WRITE_I && (ADDR_I == a);
   endfunction

   // Short periods are lifted to the floor so the output never exceeds 200 Hz
   function automatic logic [pwm_pkg::TIME_W-1:0] clamp_period(input logic [pwm_pkg::TIME_W-1:0] p);
      return (p < pwm_pkg::PERIOD_MIN_MS) ? pwm_pkg::PERIOD_MIN_MS : p;
   endfunction

   pwm_link_if link [N] ();

   // One modulator per output, no sharing
   for (genvar g = 0; g < N; g++) begin : g_inst
      assign link[g].ce = CE_I;
      assign link[g].enable = modulator_enable_coil[g];
      assign link[g].mv = mv_reg[g];
      assign link[g].period = period_reg[g];
      assign link[g].min_time = min_reg[g];
      assign gen_pwm[g] = link[g].pwm;
      assign gen_err[g] = link[g].err;

      pwm_modulator #(
         .TICK_CYCLES(TICK_CYCLES)
      ) u_mod (
         .clk_i(CORE_CLK_I),
         .reset_n_i(RESET_N_I),
         .link(link[g])
      );
   end

   // Manipulated variable registers
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         for (int i = 0; i < N; i++) begin
            mv_reg[i] <= pwm_pkg::MV_RST;
         end
      end else if (CE_I) begin
         for (int i = 0; i < N; i++) begin
            if (hit_write(reg_addr(i, pwm_pkg::OFS_MV))) begin
               mv_reg[i] <= WDATA_I[pwm_pkg::MV_W-1:0];
            end
         end
      end
   end

   // Period registers; 16 bits of ms cap the period at 65.535 s
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         for (int i = 0; i < N; i++) begin
            period_reg[i] <= pwm_pkg::PERIOD_RST;
         end
      end else if (CE_I) begin
         for (int i = 0; i < N; i++) begin
            if (hit_write(reg_addr(i, pwm_pkg::OFS_PERIOD))) begin
               period_reg[i] <= clamp_period(WDATA_I[pwm_pkg::TIME_W-1:0]);
            end
         end
      end
   end

   // Minimum on/off time registers, not checked against the period
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         for (int i = 0; i < N; i++) begin
            min_reg[i] <= pwm_pkg::MIN_RST;
         end
      end else if (CE_I) begin
         for (int i = 0; i < N; i++) begin
            if (hit_write(reg_addr(i, pwm_pkg::OFS_MIN))) begin
               min_reg[i] <= WDATA_I[pwm_pkg::TIME_W-1:0];
            end
         end
      end
   end

   // Enable coils
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         modulator_enable_coil <= '0;
      end else if (CE_I) begin
         for (int i = 0; i < N; i++) begin
            if (hit_write(reg_addr(i, pwm_pkg::OFS_CTRL))) begin
               modulator_enable_coil[i] <= WDATA_I[pwm_pkg::CTRL_EN_BIT];
            end
         end
      end
   end

   // Error rising edges raise interrupt events
   always_comb begin
      err_event = gen_err & ~err_prev;
      status_clear = '0;
      if (hit_write(pwm_pkg::OFS_IRQ_STATUS)) begin
         status_clear = WDATA_I[N-1:0];
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         err_prev <= '0;
      end else if (CE_I) begin
         err_prev <= gen_err;
      end
   end

   // A new event in the clear cycle survives the clear
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         irq_status <= '0;
      end else if (CE_I) begin
         irq_status <= (irq_status & ~status_clear) | err_event;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         irq_mask <= '0;
      end else if (CE_I) begin
         if (hit_write(pwm_pkg::OFS_IRQ_MASK)) begin
            irq_mask <= WDATA_I[N-1:0];
         end
      end
   end

   // Interrupt is registered from the next status, so it moves with status, never from a glitchy gate
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         IRQ_O <= 1'b0;
      end else if (CE_I) begin
         IRQ_O <= |((irq_status & ~status_clear | err_event) & irq_mask);
      end
   end

   // Output drive: an enabled modulator owns its pin outright
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         DIGITAL_OUTPUT_O <= '0;
         TIMING_ERROR_FLAG_O <= '0;
      end else if (CE_I) begin
         for (int i = 0; i < N; i++) begin
            if (modulator_enable_coil[i]) begin
               DIGITAL_OUTPUT_O[i] <= gen_pwm[i];
            end else begin
               DIGITAL_OUTPUT_O[i] <= OTHER_DRIVE_I[i];
            end
         end
         TIMING_ERROR_FLAG_O <= gen_err;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = '0;
      for (int i = 0; i < N; i++) begin
         if (ADDR_I == reg_addr(i, pwm_pkg::OFS_MV)) begin
            next_rdata = 32'(mv_reg[i]);
         end
         if (ADDR_I == reg_addr(i, pwm_pkg::OFS_PERIOD)) begin
            next_rdata = 32'(period_reg[i]);
         end
         if (ADDR_I == reg_addr(i, pwm_pkg::OFS_MIN)) begin
            next_rdata = 32'(min_reg[i]);
         end
         if (ADDR_I == reg_addr(i, pwm_pkg::OFS_CTRL)) begin
            next_rdata[pwm_pkg::CTRL_EN_BIT] = modulator_enable_coil[i];
         end
      end
      if (ADDR_I == pwm_pkg::OFS_STATUS) begin
         next_rdata[pwm_pkg::STATUS_ERR_LSB +: N] = gen_err;
         next_rdata[pwm_pkg::STATUS_OUT_LSB +: N] = DIGITAL_OUTPUT_O;
         next_rdata[pwm_pkg::STATUS_EN_LSB +: N] = modulator_enable_coil;
      end
      if (ADDR_I == pwm_pkg::OFS_IRQ_STATUS) begin
         next_rdata[N-1:0] = irq_status;
      end
      if (ADDR_I == pwm_pkg::OFS_IRQ_MASK) begin
         next_rdata[N-1:0] = irq_mask;
      end
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RDATA_O <= '0;
      end else if (CE_I) begin
         RDATA_O <= READ_I ? next_rdata : '0;
      end
   end
endmodule // pwm_output_block
`default_nettype wire

// >>> pwm_output_block_properties.sv
// Port-level assertions for the PWM output block
`default_nettype none
module pwm_output_block_properties #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic CORE_CLK_I, // Core clock
   input wire logic RESET_N_I, // Async reset, active low
   input wire logic CE_I, // Clock enable
   input wire logic [pwm_pkg::ADDR_W-1:0] ADDR_I, // Register address
   input wire logic [pwm_pkg::DATA_W-1:0] WDATA_I, // Write data
   input wire logic WRITE_I, // Write strobe
   input wire logic READ_I, // Read strobe
   input wire logic [pwm_pkg::NUM_INST-1:0] OTHER_DRIVE_I, // Other output sources
   input wire logic [pwm_pkg::DATA_W-1:0] RDATA_O, // Read data
   input wire logic [pwm_pkg::NUM_INST-1:0] DIGITAL_OUTPUT_O, // Output pins
   input wire logic [pwm_pkg::NUM_INST-1:0] TIMING_ERROR_FLAG_O, // Error flags
   input wire logic IRQ_O // Level interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_op;
   logic [1:0] err_q;
   logic flag_rise;
   assign rd_op = CE_I && READ_I;
   // Flag and interrupt leave the same edge, so the rise is seen with the rise of the interrupt
   assign flag_rise = |(TIMING_ERROR_FLAG_O & ~err_q);
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         err_q <= 2'b00;
      end else begin
         err_q <= TIMING_ERROR_FLAG_O;
      end
   end
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   sequence mask_set;
      $past(WRITE_I, 2) && $past(ADDR_I, 2) == 8'h28;
   endsequence
   sequence err_event;
      flag_rise;
   endsequence
   // A status clear drops the interrupt at its own edge, a mask write one edge later
   sequence irq_cleared;
      ($past(WRITE_I, 1) && $past(ADDR_I, 1) == 8'h24) || ($past(WRITE_I, 2) && $past(ADDR_I, 2) == 8'h28);
   endsequence
   a_idle_rdata: assert property (CE_I && !READ_I |=> RDATA_O == 32'h0)
      else $error("read data not zero while idle");
   a_unmapped_zero: assert property (rd_op && (ADDR_I > 8'h28 || ADDR_I[1:0] != 2'b00) |=> RDATA_O == 32'h0)
      else $error("unmapped read not zero");
   a_mv_width: assert property (rd_op && (ADDR_I == 8'h00 || ADDR_I == 8'h10) |=> RDATA_O[31:12] == 20'h0)
      else $error("manipulated variable wider than 12 bits");
   a_period_floor: assert property (rd_op && (ADDR_I == 8'h04 || ADDR_I == 8'h14)
      |=> RDATA_O[31:16] == 16'h0 && RDATA_O[15:0] >= 16'h0005)
      else $error("period below 5 ms or too wide");
   a_min_width: assert property (rd_op && (ADDR_I == 8'h08 || ADDR_I == 8'h18) |=> RDATA_O[31:16] == 16'h0)
      else $error("minimum time wider than 16 bits");
   a_status_width: assert property (rd_op && ADDR_I == 8'h20 |=> RDATA_O[31:6] == 26'h0)
      else $error("status shows more than two instances");
   a_irq_width: assert property (rd_op && (ADDR_I == 8'h24 || ADDR_I == 8'h28) |=> RDATA_O[31:2] == 30'h0)
      else $error("interrupt register too wide");
   a_irq_cause: assert property ($rose(IRQ_O) |-> mask_set or err_event)
      else $error("interrupt rose without cause");
   a_irq_drop: assert property ($fell(IRQ_O) |-> irq_cleared)
      else $error("interrupt fell without clear");
endmodule // pwm_output_block_properties
`default_nettype wire

// >>> pwm_output_block_bench.sv
// Self-checking bench for the PWM output block
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module pwm_output_block_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 4;
   typedef struct {logic lvl; int len;} seg_t;
   logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, od0 = 1'b0, od1 = 1'b0;
   logic noise = 1'b0, rd_pend = 1'b0, lvl = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, seed = 32'h8a270913, exp_r;
   logic [31:0] rdata;
   logic [1:0] dout, err;
   logic irq;
   int fails = 0, checked = 0, len = 0;
   seg_t sq[$];
   seg_t seg;
   logic [31:0] rq[$];
   logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h20, 8'h24, 8'h28, 8'h30};
   logic [31:0] rv[9] = '{32'h0, 32'h5, 32'h0, 32'h0, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] tm[7] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h1, 32'h1};
   logic [31:0] tv[7] = '{32'h332, 32'hccd, 32'h333, 32'h1, 32'h52, 32'h0, 32'hfff};
   logic te[7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   logic tout[7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   pwm_output_block #(.TICK_CYCLES(TICK)) uut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1), .ADDR_I(addr),
      .WDATA_I(wdata), .WRITE_I(we), .READ_I(re), .OTHER_DRIVE_I({od1, od0}), .RDATA_O(rdata),
      .DIGITAL_OUTPUT_O(dout), .TIMING_ERROR_FLAG_O(err), .IRQ_O(irq));
   initial begin
      forever #12.5 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Leading edge wait keeps strobe set and clear in separate steps
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      rq.push_back(e);
      @(posedge clk);
      re <= 1'b0;
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (sq.size() > 0 && n < 1500) begin
         @(posedge clk);
         n++;
      end
      if (sq.size() > 0) fails++;
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      if (rd_pend) begin
         exp_r = rq.pop_front();
         `CHK("read data", exp_r, rdata);
      end
      rd_pend <= re;
   end
   // Noise on the other source must never reach an enabled output
   always @(posedge clk) od0 <= noise && xs() > 32'h80000000;
   // Segments not expected by the queue head are ignored
   always @(posedge clk) begin
      if (dout[0] !== lvl) begin
         if (sq.size() > 0 && sq[0].lvl === lvl) begin
            seg = sq.pop_front();
            `CHK("segment length", seg.len, len);
         end
         lvl = dout[0];
         len = 1;
      end else begin
         len++;
      end
   end
   initial begin
      int p, mv, w;
      cyc(2);
      rst_n <= 1'b1;
      foreach (ra[i]) rd(ra[i], rv[i]);
      wr(8'h04, 32'h3);
      rd(8'h04, 32'h5);
      wr(8'h04, 32'hffff);
      rd(8'h04, 32'hffff);
      wr(8'h00, 32'hffffffff);
      rd(8'h00, 32'hfff);
      wr(8'h08, 32'h1ffff);
      rd(8'h08, 32'hffff);
      wr(8'h2c, 32'h1);
      rd(8'h2c, 32'h0);
      wr(8'h08, 32'h1);
      for (int k = 0; k < 4; k++) begin
         p = 100 + 10 * (k % 2);
         mv = xs() % 2458 + 819;
         w = (mv * p + 4094) / 4095 * TICK;
         wr(8'h04, p / 10);
         wr(8'h00, mv);
         wr(8'h0c, 32'h1);
         cyc(3);
         for (int j = 0; j < 5; j++) sq.push_back(seg_t'{j % 2 == 0, (j % 2 == 0) ? w : p * TICK - w});
         noise <= 1'b1;
         drain();
         noise <= 1'b0;
         cyc(2);
         wr(8'h0c, 32'h0);
      end
      od1 <= 1'b1;
      foreach (tm[i]) begin
         wr(8'h1c, 32'h0);
         wr(8'h18, tm[i]);
         wr(8'h10, tv[i]);
         wr(8'h1c, 32'h1);
         cyc(6);
         #1;
         `CHK("error flag", te[i], err[1]);
         `CHK("output two", tout[i], dout[1]);
         `CHK("interrupt", 1'b0, irq);
      end
      wr(8'h28, 32'h2);
      cyc(2);
      #1;
      `CHK("interrupt", 1'b1, irq);
      rd(8'h24, 32'h2);
      rd(8'h20, 32'h2a);
      wr(8'h1c, 32'h0);
      cyc(3);
      #1;
      `CHK("error flag", 1'b0, err[1]);
      `CHK("output two", 1'b1, dout[1]);
      wr(8'h24, 32'h2);
      cyc(3);
      #1;
      `CHK("interrupt", 1'b0, irq);
      rd(8'h24, 32'h0);
      cyc(4);
      complete_run();
   end
   initial begin
      cyc(20000);
      fails++;
      complete_run();
   end
endmodule // pwm_output_block_bench
bind pwm_output_block pwm_output_block_properties #(.TICK_CYCLES(TICK_CYCLES)) props (.CORE_CLK_I(CORE_CLK_I),
   .RESET_N_I(RESET_N_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WRITE_I(WRITE_I), .READ_I(READ_I),
   .OTHER_DRIVE_I(OTHER_DRIVE_I), .RDATA_O(RDATA_O), .DIGITAL_OUTPUT_O(DIGITAL_OUTPUT_O),
   .TIMING_ERROR_FLAG_O(TIMING_ERROR_FLAG_O), .IRQ_O(IRQ_O));
`default_nettype wire
